/* File: design/tsm_edge_sync.sv */
// Three stage pin synchroniser with edge detection
`timescale 1ns/1ps
module tsm_edge_sync
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tsm_sync_t;

   tsm_sync_t st_r;
   tsm_sync_t st_nxt;

   //----------------------------------------------------------------
   // Sampling chain
   //----------------------------------------------------------------
   // Shift pin through the stages
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Edge pulses from the settled stages only
   assign rise_o = st_r.s2 & ~st_r.s3;
   assign fall_o = ~st_r.s2 & st_r.s3;
endmodule : tsm_edge_sync

/* File: design/tsm_pkg.sv */
// Constants shared by the specialty timer files
//--------------------------------------------------------------------
// Function
// - Debug hold freezes count during break
// - Multi pulse mode disables capture and compare
// - Capture and compare share one counter
// - Reading cause register clears all earlier flags
// - Event pin bypasses prescaler, decrements counter
// - Only configured edge polarity counts
// - Counter updates third clock after edge
// - Clock source sampled like event pin
// - Capture edge rising, falling or both
// - Edge copies counter into own pair
// - Low byte read blocks capture until high
// - Capture values are read only
// - Capture sets flag; enable gates interrupt
// - Four compare values drive four pins
// - Match action set, clear or toggle
// - Compare pins reset low, init selectable
// - Mode zero forces init value, ignores matches
// - Follow mode copies output zero settings
// - Compare match sets flag; enable gates interrupt
// - Port A mode seven pin assignment
// - Debug hold is control bit seven
// - Source select encoding two bits
//--------------------------------------------------------------------
package tsm_pkg;
   localparam int CNT_W = 16;
   localparam int N_CMP = 4;
   localparam int CAUSE_W = 8;

   // Cause register bit positions
   localparam int CAUSE_EOC = 0;
   localparam int CAUSE_CAP_A = 1;
   localparam int CAUSE_CAP_B = 2;
   localparam int CAUSE_CMP0 = 3;

   // Control register bit position of debug hold
   localparam int CTRL_DEBUG_HOLD_POS = 7;

   // Source select codes
   localparam logic [1:0] SRC_SYS = 2'h0;
   localparam logic [1:0] SRC_RTC = 2'h1;
   localparam logic [1:0] SRC_EV_FALL = 2'h2;
   localparam logic [1:0] SRC_EV_RISE = 2'h3;

   // Prescaler masks for divide by 4, 16, 64, 256
   localparam logic [7:0] DIV4_MASK = 8'h03;
   localparam logic [7:0] DIV16_MASK = 8'h0F;
   localparam logic [7:0] DIV64_MASK = 8'h3F;
   localparam logic [7:0] DIV256_MASK = 8'hFF;

   // Compare action codes
   localparam logic [1:0] ACT_FORCE = 2'h0;
   localparam logic [1:0] ACT_SET = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   // Capture edge control bits
   localparam int CAPE_RISE = 0;
   localparam int CAPE_FALL = 1;

   // Values after reset, and the counter step of one
   localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h00;
   localparam logic [N_CMP-1:0] OC_RST = 4'h0;
   localparam logic [CNT_W-1:0] ONE_CNT = 16'h0001;
endpackage : tsm_pkg

/* File: design/tsm_timer.sv */
// Reload timer with event count, input capture and output compare
`timescale 1ns/1ps
module tsm_timer
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic debug_break_i,
   input wire logic [7:0] timer_ctrl_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic [1:0] clk_div_i,
   input wire logic tim_en_i,
   input wire logic tim_cont_i,
   input wire logic reload_pulse_i,
   input wire logic [15:0] reload_val_i,
   input wire logic event_count_pin_i,
   input wire logic rtc_i,
   input wire logic capture_pin_a_i,
   input wire logic capture_pin_b_i,
   input wire logic [1:0] capture_edge_ctrl_a_i,
   input wire logic [1:0] capture_edge_ctrl_b_i,
   input wire logic capture_a_lo_rd_i,
   input wire logic capture_a_hi_rd_i,
   input wire logic capture_b_lo_rd_i,
   input wire logic capture_b_hi_rd_i,
   input wire logic [63:0] compare_value_pair_i,
   input wire logic [7:0] compare_action_field_i,
   input wire logic [3:0] compare_initial_bit_i,
   input wire logic follow_output_zero_i,
   input wire logic compare_mode_enable_i,
   input wire logic multi_pulse_enable_i,
   input wire logic pair_enable_i,
   input wire logic port_a_mode7_i,
   input wire logic timer_zero_toggle_out_i,
   input wire logic timer_two_toggle_out_i,
   input wire logic eoc_irq_enable_i,
   input wire logic [1:0] capture_irq_enable_i,
   input wire logic [3:0] compare_irq_enable_i,
   input wire logic interrupt_cause_rd_i,
   output logic [15:0] count_o,
   output logic timer_done_o,
   output logic [15:0] capture_pair_a_o,
   output logic [15:0] capture_pair_b_o,
   output logic [3:0] compare_out_o,
   output logic [7:0] interrupt_cause_reg_o,
   output logic irq_o,
   output logic [5:0] port_a_func_o,
   output logic [5:0] port_a_func_oe_o,
   output logic port_a_event_sel_o
);
   typedef struct packed {
      logic [15:0] count;
      logic [7:0] pre;
      logic halted;
      logic done;
      logic [7:0] cause;
      logic [15:0] cap_a;
      logic [15:0] cap_b;
      logic lock_a;
      logic lock_b;
      logic [3:0] oc;
   } tsm_state_t;

   tsm_state_t st_r;
   tsm_state_t st_nxt;

   logic [3:0] pin_vec;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic debug_hold_bit;
   logic freeze;
   logic [7:0] div_mask;
   logic tick;
   logic run;
   logic upd;
   logic eoc;
   logic cmp_active;
   logic cap_active;
   logic hit_a;
   logic hit_b;
   logic [3:0] cmp_hit;
   logic [7:0] events;
   logic [7:0] irq_mask;
   logic [15:0] eff_val [4];
   logic [1:0] eff_act [4];
   logic [3:0] eff_init;

   //----------------------------------------------------------------
   // Pin sampling
   //----------------------------------------------------------------
   // Event pin, clock signal and both capture pins
   assign pin_vec = {capture_pin_b_i, capture_pin_a_i, rtc_i, event_count_pin_i};

   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_sync
         tsm_edge_sync u_sync
         (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .pin_i(pin_vec[g]),
            .rise_o(pin_rise[g]),
            .fall_o(pin_fall[g])
         );
      end
   endgenerate

   //----------------------------------------------------------------
   // Compare channel settings
   //----------------------------------------------------------------
   // Follow mode points channels 1 to 3 at channel 0
   generate
      for (genvar c = 0; c < tsm_pkg::N_CMP; c++)
      begin : g_cmp
         localparam int SRC = c;
         logic [1:0] sel;
         assign sel = follow_output_zero_i ? 2'h0 : SRC[1:0];
         assign eff_val[c] = compare_value_pair_i[16*sel +: 16];
         assign eff_act[c] = compare_action_field_i[2*sel +: 2];
         assign eff_init[c] = compare_initial_bit_i[sel];
      end
   endgenerate

   //----------------------------------------------------------------
   // Source and mode qualifiers
   //----------------------------------------------------------------
   // Debug hold from bit seven of control
   assign debug_hold_bit = timer_ctrl_i[tsm_pkg::CTRL_DEBUG_HOLD_POS];
   assign freeze = debug_hold_bit & debug_break_i;
   assign cmp_active = compare_mode_enable_i & ~multi_pulse_enable_i;
   assign cap_active = ~multi_pulse_enable_i;

   // Prescaler mask per divider
   always_comb
   begin
      unique case (clk_div_i)
         2'h0: div_mask = tsm_pkg::DIV4_MASK;
         2'h1: div_mask = tsm_pkg::DIV16_MASK;
         2'h2: div_mask = tsm_pkg::DIV64_MASK;
         2'h3: div_mask = tsm_pkg::DIV256_MASK;
      endcase
   end

   // Count tick from the selected source
   always_comb
   begin
      unique case (clk_sel_i)
         tsm_pkg::SRC_SYS: tick = (st_r.pre & div_mask) == div_mask;
         tsm_pkg::SRC_RTC: tick = pin_rise[1];
         tsm_pkg::SRC_EV_FALL: tick = pin_fall[0];
         tsm_pkg::SRC_EV_RISE: tick = pin_rise[0];
      endcase
   end

   // Capture hits, blocked while a pair is half read
   assign hit_a = cap_active & ~st_r.lock_a & ~capture_a_lo_rd_i
      & ((capture_edge_ctrl_a_i[tsm_pkg::CAPE_RISE] & pin_rise[2])
      | (capture_edge_ctrl_a_i[tsm_pkg::CAPE_FALL] & pin_fall[2]));
   assign hit_b = cap_active & ~st_r.lock_b & ~capture_b_lo_rd_i
      & ((capture_edge_ctrl_b_i[tsm_pkg::CAPE_RISE] & pin_rise[3])
      | (capture_edge_ctrl_b_i[tsm_pkg::CAPE_FALL] & pin_fall[3]));

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------
   // Counter, capture, compare and cause flags
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      upd = 1'b0;
      eoc = 1'b0;
      cmp_hit = 4'h0;
      run = tim_en_i & ~st_r.halted & ~freeze;
      if (!freeze)
      begin
         st_nxt.pre = st_r.pre + 8'h01;
      end
      if (!tim_en_i)
      begin
         st_nxt.halted = 1'b0;
      end
      // Reload, or one step per qualifying tick
      if (reload_pulse_i)
      begin
         st_nxt.count = reload_val_i;
         st_nxt.halted = 1'b0;
      end
      else if (run && tick)
      begin
         upd = 1'b1;
         if (st_r.count == tsm_pkg::ONE_CNT)
         begin
            eoc = 1'b1;
            if (tim_cont_i)
            begin
               st_nxt.count = reload_val_i;
            end
            else
            begin
               st_nxt.count = tsm_pkg::COUNT_RST;
               st_nxt.halted = 1'b1;
               st_nxt.done = 1'b1;
            end
         end
         else
         begin
            st_nxt.count = st_r.count - tsm_pkg::ONE_CNT;
         end
      end
      // Compare actions on the shared counter
      for (int i = 0; i < tsm_pkg::N_CMP; i++)
      begin
         if (eff_act[i] == tsm_pkg::ACT_FORCE)
         begin
            st_nxt.oc[i] = eff_init[i];
         end
         else if (cmp_active && upd && st_nxt.count == eff_val[i])
         begin
            cmp_hit[i] = 1'b1;
            unique case (eff_act[i])
               tsm_pkg::ACT_SET: st_nxt.oc[i] = 1'b1;
               tsm_pkg::ACT_CLEAR: st_nxt.oc[i] = 1'b0;
               tsm_pkg::ACT_TOGGLE: st_nxt.oc[i] = ~st_r.oc[i];
               default: st_nxt.oc[i] = st_r.oc[i];
            endcase
         end
      end
      // Capture copies the counter into its own pair
      if (hit_a)
      begin
         st_nxt.cap_a = st_r.count;
      end
      if (hit_b)
      begin
         st_nxt.cap_b = st_r.count;
      end
      // Half read lock per pair
      if (capture_a_hi_rd_i)
      begin
         st_nxt.lock_a = 1'b0;
      end
      if (capture_a_lo_rd_i)
      begin
         st_nxt.lock_a = 1'b1;
      end
      if (capture_b_hi_rd_i)
      begin
         st_nxt.lock_b = 1'b0;
      end
      if (capture_b_lo_rd_i)
      begin
         st_nxt.lock_b = 1'b1;
      end
      // Read clears, new events set on top
      events = 8'h00;
      events[tsm_pkg::CAUSE_EOC] = eoc;
      events[tsm_pkg::CAUSE_CAP_A] = hit_a;
      events[tsm_pkg::CAUSE_CAP_B] = hit_b;
      events[tsm_pkg::CAUSE_CMP0 +: 4] = cmp_hit;
      st_nxt.cause = (interrupt_cause_rd_i ? tsm_pkg::CAUSE_RST : st_r.cause) | events;
   end

   //----------------------------------------------------------------
   // State register
   //----------------------------------------------------------------
   // Every field registered, constants on reset
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r.count <= tsm_pkg::COUNT_RST;
         st_r.pre <= tsm_pkg::PRE_RST;
         st_r.halted <= 1'b0;
         st_r.done <= 1'b0;
         st_r.cause <= tsm_pkg::CAUSE_RST;
         st_r.cap_a <= tsm_pkg::COUNT_RST;
         st_r.cap_b <= tsm_pkg::COUNT_RST;
         st_r.lock_a <= 1'b0;
         st_r.lock_b <= 1'b0;
         st_r.oc <= tsm_pkg::OC_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   // Register views; capture values have no write path
   assign count_o = st_r.count;
   assign timer_done_o = st_r.done;
   assign capture_pair_a_o = st_r.cap_a;
   assign capture_pair_b_o = st_r.cap_b;
   assign compare_out_o = st_r.oc;
   assign interrupt_cause_reg_o = st_r.cause;

   // Interrupt from enabled flags only
   always_comb
   begin
      irq_mask = 8'h00;
      irq_mask[tsm_pkg::CAUSE_EOC] = eoc_irq_enable_i;
      irq_mask[tsm_pkg::CAUSE_CAP_A] = capture_irq_enable_i[0];
      irq_mask[tsm_pkg::CAUSE_CAP_B] = capture_irq_enable_i[1];
      irq_mask[tsm_pkg::CAUSE_CMP0 +: 4] = compare_irq_enable_i;
   end
   assign irq_o = |(st_r.cause & irq_mask);

   // Port A alternate function routing
   assign port_a_func_o = {timer_two_toggle_out_i, timer_zero_toggle_out_i, st_r.oc};
   assign port_a_func_oe_o[3:0] = {4{port_a_mode7_i & ~multi_pulse_enable_i}};
   assign port_a_func_oe_o[5:4] = {2{port_a_mode7_i & ~pair_enable_i}};
   assign port_a_event_sel_o = port_a_mode7_i & ~pair_enable_i;
endmodule : tsm_timer

/* File: test/tsm_pin_model.sv */
// Far side pin drivers with minimum edge spacing
`timescale 1ns/1ps
module tsm_pin_model
(
   input wire logic sys_clk_i,
   input wire logic [3:0] req_i,
   output logic event_count_pin_o,
   output logic rtc_o,
   output logic capture_pin_a_o,
   output logic capture_pin_b_o
);
   logic [3:0] pin_r = 4'h0;
   logic [3:0] pend = 4'h0;
   logic [2:0] gap [4] = '{3'h7, 3'h7, 3'h7, 3'h7};

   // Toggle on request, held back until three clocks passed
   always @(posedge sys_clk_i)
   begin
      pend = pend | req_i;
      for (int k = 0; k < 4; k++)
      begin
         if (gap[k] != 3'h7)
            gap[k] = gap[k] + 3'h1;
         if (pend[k] && gap[k] >= 3'h3)
         begin
            pin_r[k] <= ~pin_r[k];
            pend[k] = 1'b0;
            gap[k] = 3'h0;
         end
      end
   end

   // Pins to the timer
   assign {capture_pin_b_o, capture_pin_a_o, rtc_o, event_count_pin_o} = pin_r;
endmodule : tsm_pin_model

/* File: test/tsm_timer_assertions.sv */
// Concurrent checks on the specialty timer ports
`timescale 1ns/1ps
module tsm_timer_assertions
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic debug_break_i,
   input wire logic [7:0] timer_ctrl_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic tim_en_i,
   input wire logic reload_pulse_i,
   input wire logic event_count_pin_i,
   input wire logic capture_a_lo_rd_i,
   input wire logic capture_a_hi_rd_i,
   input wire logic [63:0] compare_value_pair_i,
   input wire logic [7:0] compare_action_field_i,
   input wire logic [3:0] compare_initial_bit_i,
   input wire logic follow_output_zero_i,
   input wire logic compare_mode_enable_i,
   input wire logic multi_pulse_enable_i,
   input wire logic eoc_irq_enable_i,
   input wire logic [1:0] capture_irq_enable_i,
   input wire logic [3:0] compare_irq_enable_i,
   input wire logic interrupt_cause_rd_i,
   input wire logic [15:0] count_o,
   input wire logic [15:0] capture_pair_a_o,
   input wire logic [3:0] compare_out_o,
   input wire logic [7:0] interrupt_cause_reg_o,
   input wire logic irq_o
);
   // One clock domain, reset disables every check
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_irq_or:
      assert property (irq_o == |(interrupt_cause_reg_o & {1'b0, compare_irq_enable_i,
         capture_irq_enable_i, eoc_irq_enable_i})) else $error("irq not OR of enabled flags");
   chk_cause_clr:
      assert property (interrupt_cause_rd_i ##1 $stable(count_o) |-> (interrupt_cause_reg_o & 8'h79) == 8'h00)
      else $error("cause flags kept after read");
   chk_debug_freeze:
      assert property (debug_break_i && timer_ctrl_i[7] && !reload_pulse_i |=> $stable(count_o))
      else $error("count moved during hold");
   chk_cap_value:
      assert property ($changed(capture_pair_a_o) |-> capture_pair_a_o == $past(count_o))
      else $error("capture value not counter");
   chk_cap_lock:
      assert property (capture_a_lo_rd_i ##1 !capture_a_hi_rd_i [*3] |-> $stable(capture_pair_a_o))
      else $error("capture changed while locked");
   chk_pulse_block:
      assert property (multi_pulse_enable_i |=> $stable(capture_pair_a_o)
         && (interrupt_cause_reg_o & ~$past(interrupt_cause_reg_o) & 8'h7E) == 8'h00)
      else $error("capture or compare in multi pulse mode");
   chk_evt_step:
      assert property ($rose(event_count_pin_i) && clk_sel_i == 2'h3 && count_o > 16'h0002
         ##1 (tim_en_i && !debug_break_i && !reload_pulse_i && clk_sel_i == 2'h3) [*2]
         |=> count_o == $past(count_o) - 16'h0001) else $error("event did not decrement");
   chk_cmp_set:
      assert property (compare_mode_enable_i && !multi_pulse_enable_i && compare_action_field_i[1:0] == 2'h1
         ##1 $changed(count_o) && count_o == compare_value_pair_i[15:0]
         |-> compare_out_o[0] && interrupt_cause_reg_o[3]) else $error("set match missed");
   chk_force_init:
      assert property (compare_action_field_i[1:0] == 2'h0 |=> compare_out_o[0] == $past(compare_initial_bit_i[0]))
      else $error("forced level wrong");
   chk_follow_zero:
      assert property (follow_output_zero_i && compare_action_field_i[1:0] == 2'h0
         |=> compare_out_o == {4{$past(compare_initial_bit_i[0])}}) else $error("outputs not following zero");
endmodule : tsm_timer_assertions

bind tsm_timer tsm_timer_assertions chk_i (.*);

/* File: test/tsm_timer_tb.sv */
// Self-checking bench for the specialty timer
`timescale 1ns/1ps
module tsm_timer_tb;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, debug_break_i = 1'b0, tim_en_i = 1'b0, tim_cont_i = 1'b1;
   logic reload_pulse_i = 1'b0, follow_output_zero_i = 1'b0, compare_mode_enable_i = 1'b0;
   logic capture_a_lo_rd_i = 1'b0, capture_a_hi_rd_i = 1'b0, capture_b_lo_rd_i = 1'b0, capture_b_hi_rd_i = 1'b0;
   logic multi_pulse_enable_i = 1'b0, pair_enable_i = 1'b0, port_a_mode7_i = 1'b0, eoc_irq_enable_i = 1'b0;
   logic timer_zero_toggle_out_i = 1'b0, timer_two_toggle_out_i = 1'b0, interrupt_cause_rd_i = 1'b0;
   logic [7:0] timer_ctrl_i = 8'h00, compare_action_field_i = 8'h00, interrupt_cause_reg_o;
   logic [1:0] clk_sel_i = 2'h3, clk_div_i = 2'h0, capture_edge_ctrl_a_i = 2'h1, capture_edge_ctrl_b_i = 2'h2;
   logic [1:0] capture_irq_enable_i = 2'h1;
   logic [3:0] compare_initial_bit_i = 4'h0, compare_irq_enable_i = 4'h1, compare_out_o, req = 4'h0;
   logic [15:0] reload_val_i = 16'h0000, count_o, capture_pair_a_o, capture_pair_b_o, rnd = 16'h0057, e, v;
   logic [63:0] compare_value_pair_i = 64'h0000;
   logic event_count_pin_i, rtc_i, capture_pin_a_i, capture_pin_b_i, timer_done_o, irq_o, port_a_event_sel_o;
   logic [5:0] port_a_func_o, port_a_func_oe_o;
   int n_fail = 0, checks_done = 0, n;

   tsm_timer dut (.*);
   tsm_pin_model pm (.sys_clk_i(sys_clk_i), .req_i(req), .event_count_pin_o(event_count_pin_i),
      .rtc_o(rtc_i), .capture_pin_a_o(capture_pin_a_i), .capture_pin_b_o(capture_pin_b_i));

   // 40 MHz clock
   always #12.5 sys_clk_i = ~sys_clk_i;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic [5:0] exp_oe(input logic m7, input logic pr, input logic mp);
      return {{2{m7 & ~pr}}, {4{m7 & ~mp}}};
   endfunction : exp_oe

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk_i);
      #2;
   endtask : step

   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(1);
   endtask : pulse

   task automatic tog(input int k, input int m);
      repeat (m)
      begin
         req[k] = 1'b1;
         step(1);
         req[k] = 1'b0;
         step(4);
      end
      step(4);
   endtask : tog

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic wait_bit(input int b);
      int i;
      for (i = 0; i < 50 && interrupt_cause_reg_o[b] !== 1'b1; i++)
         step(1);
      if (i == 50)
      begin
         n_fail++;
         finish_test();
      end
   endtask : wait_bit

   // Main sequence
   initial
   begin
      step(8);
      rst_i = 1'b0;
      chk(count_o, 16'h0000);
      chk(compare_out_o, 4'h0);
      chk(interrupt_cause_reg_o, 8'h00);
      rnd = lfsr(rnd);
      e = rnd | 16'h0100;
      n = int'(rnd[1:0]) + 1;
      reload_val_i = e;
      pulse(reload_pulse_i);
      tim_en_i = 1'b1;
      tog(0, 2 * n);
      e = e - 16'(n);
      chk(count_o, e);
      clk_sel_i = 2'h2;
      tog(0, 2 * n);
      e = e - 16'(n);
      chk(count_o, e);
      clk_sel_i = 2'h1;
      tog(1, 2 * n);
      e = e - 16'(n);
      chk(count_o, e);
      clk_sel_i = 2'h3;
      req[0] = 1'b1;
      step(1);
      req[0] = 1'b0;
      step(2);
      chk(count_o, e);
      step(1);
      chk(count_o, e - 16'h0001);
      tog(0, 1);
      e = e - 16'h0001;
      clk_sel_i = 2'h0;
      timer_ctrl_i = 8'h80;
      debug_break_i = 1'b1;
      step(40);
      chk(count_o, e);
      timer_ctrl_i = 8'h00;
      step(20);
      chk(count_o, e - 16'h0005);
      tim_en_i = 1'b0;
      debug_break_i = 1'b0;
      rnd = lfsr(rnd);
      v = rnd;
      reload_val_i = v;
      pulse(reload_pulse_i);
      tog(3, 2);
      wait_bit(2);
      chk(capture_pair_b_o, v);
      chk(irq_o, 1'b0);
      tog(2, 1);
      wait_bit(1);
      chk(capture_pair_a_o, v);
      chk(irq_o, 1'b1);
      pulse(interrupt_cause_rd_i);
      chk(interrupt_cause_reg_o, 8'h00);
      chk(irq_o, 1'b0);
      pulse(capture_a_lo_rd_i);
      capture_edge_ctrl_a_i = 2'h3;
      rnd = lfsr(rnd);
      reload_val_i = rnd;
      pulse(reload_pulse_i);
      tog(2, 2);
      chk(capture_pair_a_o, v);
      pulse(capture_a_hi_rd_i);
      pulse(interrupt_cause_rd_i);
      tog(2, 1);
      wait_bit(1);
      chk(capture_pair_a_o, rnd);
      // Capture lands on the same edge as a cause read
      req[2] = 1'b1;
      step(1);
      req[2] = 1'b0;
      step(2);
      interrupt_cause_rd_i = 1'b1;
      step(1);
      interrupt_cause_rd_i = 1'b0;
      chk(interrupt_cause_reg_o, 8'h02);
      chk(capture_pair_a_o, rnd);
      v = rnd;
      clk_sel_i = 2'h3;
      reload_val_i = 16'h0005;
      pulse(reload_pulse_i);
      compare_value_pair_i = {16'h0003, 16'h0003, 16'h0004, 16'h0003};
      compare_initial_bit_i = 4'hC;
      step(2);
      chk(compare_out_o, 4'hC);
      compare_action_field_i = 8'h2D;
      compare_mode_enable_i = 1'b1;
      tim_en_i = 1'b1;
      pulse(interrupt_cause_rd_i);
      tog(0, 2);
      chk(compare_out_o, 4'hE);
      tog(0, 4);
      chk(compare_out_o, 4'hB);
      chk(interrupt_cause_reg_o & 8'h78, 8'h38);
      chk(irq_o, 1'b1);
      follow_output_zero_i = 1'b1;
      compare_action_field_i = 8'hFC;
      compare_initial_bit_i = 4'h1;
      step(2);
      chk(compare_out_o, 4'hF);
      compare_initial_bit_i = 4'hE;
      step(2);
      chk(compare_out_o, 4'h0);
      follow_output_zero_i = 1'b0;
      compare_action_field_i = 8'h55;
      compare_value_pair_i[15:0] = 16'h0001;
      multi_pulse_enable_i = 1'b1;
      pulse(interrupt_cause_rd_i);
      tog(0, 2);
      tog(2, 1);
      chk(compare_out_o, 4'h0);
      chk(interrupt_cause_reg_o, 8'h00);
      chk(capture_pair_a_o, v);
      for (int i = 0; i < 16; i++)
      begin
         {port_a_mode7_i, pair_enable_i, multi_pulse_enable_i, timer_zero_toggle_out_i} = i[3:0];
         timer_two_toggle_out_i = ~i[0];
         step(1);
         chk(port_a_func_oe_o, exp_oe(i[3], i[2], i[1]));
         chk(port_a_func_o[5:4], {~i[0], i[0]});
         chk(port_a_event_sel_o, i[3] & ~i[2]);
         chk(port_a_func_o[3:0], 4'h0);
      end
      // Single pass on the divide by 16 system source
      multi_pulse_enable_i = 1'b0;
      compare_mode_enable_i = 1'b0;
      tim_cont_i = 1'b0;
      clk_sel_i = 2'h0;
      clk_div_i = 2'h1;
      eoc_irq_enable_i = 1'b1;
      reload_val_i = 16'h0002;
      pulse(reload_pulse_i);
      pulse(interrupt_cause_rd_i);
      wait_bit(0);
      chk(timer_done_o, 1'b1);
      chk(count_o, 16'h0000);
      chk(irq_o, 1'b1);
      step(1);
      chk(timer_done_o, 1'b0);
      step(20);
      chk(count_o, 16'h0000);
      finish_test();
   end
endmodule : tsm_timer_tb
